// >>> pkg/scm_pkg.sv
// Purpose: shared constants and types for the system clock and mode control block
// Assumes: 250 MHz reference clock, oscillator outputs arrive as one-cycle ticks
// Notes:   register offsets are word indices on the plain register port
`default_nettype none

package scm_pkg;

  // register offsets
  localparam logic [1:0] SCM_SYS_CTRL_ADDR = 2'h0;
  localparam logic [1:0] SCM_OSC_CTRL_ADDR = 2'h1;

  // system_clock_control fields
  localparam int         SCM_SEL_MSB      = 7;
  localparam int         SCM_SEL_LSB      = 5;
  localparam int         SCM_FAST_KEEP_BIT = 1;
  localparam int         SCM_FS_KEEP_BIT  = 0;

  // fast_osc_control fields
  localparam int         SCM_FREQ_MSB     = 3;
  localparam int         SCM_FREQ_LSB     = 2;
  localparam int         SCM_STABLE_BIT   = 1;
  localparam int         SCM_ON_BIT       = 0;

  // values after reset
  localparam logic [2:0] SCM_SEL_RST      = 3'h0;
  localparam logic       SCM_KEEP_RST     = 1'b0;
  localparam logic [1:0] SCM_FREQ_RST     = 2'h0;
  localparam logic       SCM_ON_RST       = 1'b1;

  // select code for the sub clock, and divider depth
  localparam logic [2:0] SCM_SEL_SUB      = 3'h7;
  localparam logic [2:0] SCM_SEL_MAXDIV   = 3'h6;
  localparam logic [5:0] SCM_DIV_FULL     = 6'h3F;

  // fast oscillator frequency codes and slow oscillator frequency
  localparam logic [1:0] SCM_FREQ_2MHZ    = 2'h0;
  localparam logic [1:0] SCM_FREQ_4MHZ    = 2'h1;
  localparam logic [1:0] SCM_FREQ_8MHZ    = 2'h2;
  localparam logic [1:0] SCM_FREQ_ALT2MHZ = 2'h3;
  localparam int         SCM_SLOW_OSC_HZ  = 32000;

  // fast oscillator settling time
  localparam int         SCM_CLK_PERIOD_PS = 4000;
  localparam int         SCM_SETTLE_NS     = 16000;
  localparam int         SCM_SETTLE_CYCLES =
    (SCM_SETTLE_NS * 1000 + SCM_CLK_PERIOD_PS - 1) / SCM_CLK_PERIOD_PS;

  typedef enum logic [5:0] {
    SCM_MODE_FAST      = 6'h01,
    SCM_MODE_SLOW      = 6'h02,
    SCM_MODE_SLEEP     = 6'h04,
    SCM_MODE_LOW_IDLE  = 6'h08,
    SCM_MODE_FULL_IDLE = 6'h10,
    SCM_MODE_HIGH_IDLE = 6'h20
  } scm_mode_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } scm_reg_req_t;

  typedef struct packed {
    logic cpu_sys_clk;
    logic high_clk;
    logic sub_clk;
    logic slow_osc_clk;
  } scm_clk_ticks_t;

endpackage

`default_nettype wire

// >>> hdl/scm_clock_mode_ctrl.sv
// Purpose: system clock select, fast oscillator control and operating mode control
// Assumes: oscillator outputs are one-cycle ticks synchronous to ref_clk_i
// Notes:   every clock leaves the block as a tick; gating a tick cannot make a runt
`timescale 1ns/10ps
`default_nettype none

module scm_clock_mode_ctrl #(
  parameter int SETTLE_CYCLES = scm_pkg::SCM_SETTLE_CYCLES
) (
  input  wire logic                   ref_clk_i,        // 250 MHz clock
  input  wire logic                   rst_n_i,          // synchronous reset, active low
  input  wire scm_pkg::scm_reg_req_t  reg_req_i,        // register access request
  output logic [7:0]                  reg_rdata_o,      // read data, one cycle after read
  input  wire logic                   halt_i,           // cpu executes halt, pulse
  input  wire logic                   wake_i,           // wake-up event, pulse
  input  wire logic                   fast_osc_tick_i,  // fast oscillator edge tick
  input  wire logic                   slow_osc_tick_i,  // slow oscillator edge tick
  output logic                        fast_osc_run_o,   // fast oscillator power on
  output logic [1:0]                  fast_osc_freq_o,  // fast oscillator trim code
  output logic                        slow_osc_run_o,   // slow oscillator power on
  output scm_pkg::scm_clk_ticks_t     clk_ticks_o,      // gated clock ticks
  output logic                        cpu_run_o,        // cpu may execute
  output scm_pkg::scm_mode_t          mode_o            // current operating mode
);
  import scm_pkg::*;

  localparam int CW = $clog2(SETTLE_CYCLES + 1);

  // a zero settle time would leave the stable flag unreachable
  if (SETTLE_CYCLES < 1) begin : g_bad_settle
    $error("SETTLE_CYCLES must be at least 1");
  end

  logic [2:0]     sel_reg;
  logic           fast_keep_reg;
  logic           fs_keep_reg;
  logic [1:0]     freq_sel_reg;
  logic           osc_on_reg;
  logic           stable_reg;
  logic [CW-1:0]  settle_cnt_reg;
  logic           fast_need_reg;
  logic [2:0]     act_sel_reg;
  logic [5:0]     div_cnt_reg;
  logic [1:0]     freq_out_reg;
  scm_mode_t      mode_reg;
  scm_mode_t      mode_next;
  scm_clk_ticks_t ticks_reg;
  logic [7:0]     rdata_reg;
  logic           cpu_run_reg;
  logic           slow_run_reg;

  logic       ctl_wr;
  logic       osc_wr;
  logic       fast_need;
  logic       restart;
  logic       high_tick;
  logic       div_tick;
  logic [5:0] div_mask;
  logic       sys_tick_raw;
  logic       sys_on;
  logic       sub_on;
  logic       switch_ok;
  logic       running;
  scm_mode_t  run_mode;

  assign ctl_wr  = reg_req_i.wr && (reg_req_i.addr == SCM_SYS_CTRL_ADDR);
  assign osc_wr  = reg_req_i.wr && (reg_req_i.addr == SCM_OSC_CTRL_ADDR);
  assign running = (mode_reg == SCM_MODE_FAST) || (mode_reg == SCM_MODE_SLOW);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sel_reg      <= SCM_SEL_RST;
      fast_keep_reg <= SCM_KEEP_RST;
      fs_keep_reg  <= SCM_KEEP_RST;
      freq_sel_reg <= SCM_FREQ_RST;
      osc_on_reg   <= SCM_ON_RST;
    end else begin
      if (ctl_wr) begin
        sel_reg       <= reg_req_i.wdata[SCM_SEL_MSB:SCM_SEL_LSB];
        fast_keep_reg <= reg_req_i.wdata[SCM_FAST_KEEP_BIT];
        fs_keep_reg   <= reg_req_i.wdata[SCM_FS_KEEP_BIT];
      end
      if (osc_wr) begin
        freq_sel_reg <= reg_req_i.wdata[SCM_FREQ_MSB:SCM_FREQ_LSB];
        osc_on_reg   <= reg_req_i.wdata[SCM_ON_BIT];
      end
    end
  end

  // register read, data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
    end else if (reg_req_i.rd && reg_req_i.addr == SCM_SYS_CTRL_ADDR) begin
      rdata_reg <= {sel_reg, 3'h0, fast_keep_reg, fs_keep_reg};
    end else if (reg_req_i.rd && reg_req_i.addr == SCM_OSC_CTRL_ADDR) begin
      rdata_reg <= {4'h0, freq_sel_reg, stable_reg, osc_on_reg};
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // fast oscillator demand per mode; a pending fast select keeps it alive in slow mode
  always_comb begin
    case (mode_reg)
      SCM_MODE_FAST:      fast_need = 1'b1;
      // enable bit rules in slow mode
      SCM_MODE_SLOW:      fast_need = osc_on_reg || (sel_reg != SCM_SEL_SUB);
      SCM_MODE_FULL_IDLE: fast_need = 1'b1;
      SCM_MODE_HIGH_IDLE: fast_need = 1'b1;
      default:            fast_need = 1'b0;
    endcase
  end

  assign restart = (fast_need && !fast_need_reg) ||
                   (osc_wr && fast_need_reg &&
                    reg_req_i.wdata[SCM_FREQ_MSB:SCM_FREQ_LSB] != freq_sel_reg);

  // stable flag clears on start and sets after settling
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      fast_need_reg  <= 1'b0;
      stable_reg     <= 1'b0;
      settle_cnt_reg <= '0;
    end else begin
      fast_need_reg <= fast_need;
      if (!fast_need_reg || restart) begin
        stable_reg     <= 1'b0;
        settle_cnt_reg <= '0;
      end else if (!stable_reg) begin
        if (settle_cnt_reg == CW'(SETTLE_CYCLES - 1)) begin
          stable_reg <= 1'b1;
        end else begin
          settle_cnt_reg <= settle_cnt_reg + 1'b1;
        end
      end
    end
  end

  // code 11 trims the oscillator to 2 MHz
  // only three frequencies leave the block
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      freq_out_reg <= SCM_FREQ_2MHZ;
    end else if (freq_sel_reg == SCM_FREQ_ALT2MHZ) begin
      freq_out_reg <= SCM_FREQ_2MHZ;
    end else begin
      freq_out_reg <= freq_sel_reg;
    end
  end

  // ticks are ignored until the new frequency has settled
  // live demand, so no fast tick slips out on the edge after entering sleep
  assign high_tick = fast_osc_tick_i && stable_reg && fast_need;

  // divide by 2 to the power of the select code
  assign div_mask     = SCM_DIV_FULL >> (3'(SCM_SEL_MAXDIV - act_sel_reg));
  assign div_tick     = high_tick && ((div_cnt_reg & div_mask) == div_mask);
  // select 111 takes the slow oscillator tick
  // sub clock is the slow oscillator itself
  assign sys_tick_raw = (act_sel_reg == SCM_SEL_SUB) ? slow_osc_tick_i : div_tick;

  // switch only at a period edge, or when the old source is dead
  // and only toward a source that is already stable
  assign switch_ok = (sel_reg != act_sel_reg) &&
                     (sys_tick_raw || (act_sel_reg != SCM_SEL_SUB && !stable_reg)) &&
                     (sel_reg == SCM_SEL_SUB || stable_reg);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      act_sel_reg <= SCM_SEL_RST;
      div_cnt_reg <= 6'h00;
    end else if (switch_ok) begin
      act_sel_reg <= sel_reg;
      div_cnt_reg <= 6'h00;
    end else if (high_tick) begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end

  // system and sub clock gating per mode
  always_comb begin
    case (mode_reg)
      SCM_MODE_FAST:      sys_on = 1'b1;
      SCM_MODE_SLOW:      sys_on = 1'b1;
      // system clock only while the sub clock is selected
      SCM_MODE_LOW_IDLE:  sys_on = (act_sel_reg == SCM_SEL_SUB);
      // all clocks run whatever the select
      SCM_MODE_FULL_IDLE: sys_on = 1'b1;
      // system clock only for divided fast selects
      SCM_MODE_HIGH_IDLE: sys_on = (act_sel_reg != SCM_SEL_SUB);
      default:            sys_on = 1'b0;
    endcase
  end

  // sleep stops the sub clock too
  assign sub_on = (mode_reg != SCM_MODE_SLEEP) && (mode_reg != SCM_MODE_HIGH_IDLE);

  assign run_mode = (act_sel_reg == SCM_SEL_SUB) ? SCM_MODE_SLOW : SCM_MODE_FAST;

  // halt picks a low-power mode from the keep bits
  always_comb begin
    case (mode_reg)
      SCM_MODE_FAST, SCM_MODE_SLOW: begin
        if (halt_i) begin
          case ({fast_keep_reg, fs_keep_reg})
            2'b01:   mode_next = SCM_MODE_LOW_IDLE;
            2'b11:   mode_next = SCM_MODE_FULL_IDLE;
            2'b10:   mode_next = SCM_MODE_HIGH_IDLE;
            default: mode_next = SCM_MODE_SLEEP;
          endcase
        end else begin
          mode_next = run_mode;
        end
      end
      SCM_MODE_SLEEP, SCM_MODE_LOW_IDLE, SCM_MODE_FULL_IDLE, SCM_MODE_HIGH_IDLE: begin
        // wake-up returns by the current select
        mode_next = wake_i ? run_mode : mode_reg;
      end
      default: mode_next = run_mode;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mode_reg    <= SCM_MODE_FAST;
      cpu_run_reg <= 1'b0;
    end else begin
      mode_reg    <= mode_next;
      cpu_run_reg <= running;
    end
  end

  // watchdog and time base share the slow and fast ticks
  // slow oscillator tick is never gated
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ticks_reg <= '0;
    end else begin
      ticks_reg.cpu_sys_clk  <= sys_on && sys_tick_raw;
      ticks_reg.high_clk     <= high_tick;
      ticks_reg.sub_clk      <= sub_on && slow_osc_tick_i;
      ticks_reg.slow_osc_clk <= slow_osc_tick_i;
    end
  end

  // power request held high through reset as well
  always_ff @(posedge ref_clk_i) begin
    slow_run_reg <= 1'b1;
  end

  assign reg_rdata_o     = rdata_reg;
  assign fast_osc_run_o  = fast_need_reg;
  assign fast_osc_freq_o = freq_out_reg;
  // slow oscillator always powered, watchdog cannot be disabled
  assign slow_osc_run_o  = slow_run_reg;
  assign clk_ticks_o     = ticks_reg;
  assign cpu_run_o       = cpu_run_reg;
  assign mode_o          = mode_reg;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  fast_div_a: assert property (
    (running && act_sel_reg == 3'h1 && fast_osc_tick_i && stable_reg && fast_need_reg
     && div_cnt_reg[0] == 1'b0 && !switch_ok) |=> !clk_ticks_o.cpu_sys_clk)
    else $error("divide by two emitted a tick on an even count");
  sub_sys_a: assert property (
    (running && act_sel_reg == SCM_SEL_SUB && slow_osc_tick_i) |=> clk_ticks_o.cpu_sys_clk)
    else $error("sub clock tick did not reach the cpu clock");
  cpu_halt_a: assert property (
    (running && halt_i) |-> ##2 !cpu_run_o)
    else $error("cpu still running after halt");
  sleep_stop_a: assert property (
    (mode_reg == SCM_MODE_SLEEP)[*2] |-> (!clk_ticks_o.cpu_sys_clk && !clk_ticks_o.sub_clk
                                          && !clk_ticks_o.high_clk && !fast_osc_run_o))
    else $error("clock running in sleep");
  low_idle_a: assert property (
    (mode_reg == SCM_MODE_LOW_IDLE)[*2] |-> (!clk_ticks_o.high_clk && !fast_osc_run_o))
    else $error("fast clock running in low-only idle");
  full_idle_a: assert property (
    (mode_reg == SCM_MODE_FULL_IDLE && slow_osc_tick_i) |=> clk_ticks_o.sub_clk)
    else $error("sub clock stopped in full idle");
  high_idle_a: assert property (
    (mode_reg == SCM_MODE_HIGH_IDLE)[*2] |-> (!clk_ticks_o.sub_clk && fast_osc_run_o))
    else $error("wrong clocks in high-only idle");
  wdt_alive_a: assert property (
    slow_osc_tick_i |=> (clk_ticks_o.slow_osc_clk && slow_osc_run_o))
    else $error("slow oscillator tick lost");
  freq_map_a: assert property (
    (freq_sel_reg == SCM_FREQ_ALT2MHZ) |=> (fast_osc_freq_o == SCM_FREQ_2MHZ))
    else $error("code 11 not mapped to 2 MHz");
  stable_wait_a: assert property (
    $rose(stable_reg) |-> $past(settle_cnt_reg) == CW'(SETTLE_CYCLES - 1))
    else $error("stable flag set before settling time");
  reset_val_a: assert property (
    @(posedge ref_clk_i) disable iff (1'b0)
    !rst_n_i |=> (sel_reg == 3'h0 && !fast_keep_reg && !fs_keep_reg && freq_sel_reg == 2'h0
                  && !stable_reg && osc_on_reg))
    else $error("wrong value after reset");
  safe_switch_a: assert property (
    ($changed(act_sel_reg) && act_sel_reg != SCM_SEL_SUB) |-> $past(stable_reg))
    else $error("switched to an unstable fast clock");
  wake_run_a: assert property (
    (!running && wake_i) |=> (mode_reg == SCM_MODE_FAST || mode_reg == SCM_MODE_SLOW))
    else $error("wake-up did not restore a running mode");

endmodule

`default_nettype wire

// >>> verification/scm_clock_mode_ctrl_tb.sv
// Purpose: self-checking bench for the system clock and mode control block
// Assumes: oscillator ticks are driven here as one-cycle pulses; settling shortened to 8 cycles
// Notes:   tick counts are taken over whole windows so any divider phase gives an exact figure
`timescale 1ns/10ps
`default_nettype none

module scm_clock_mode_ctrl_tb;
  import scm_pkg::*;
  localparam int SETTLE = 8;
  logic           ref_clk_i;
  logic           rst_n_i;
  scm_reg_req_t   reg_req_i;
  logic [7:0]     reg_rdata_o;
  logic           halt_i;
  logic           wake_i;
  logic           fast_tick;
  logic           slow_tick;
  logic           fast_run;
  logic [1:0]     fast_freq;
  logic           slow_run;
  scm_clk_ticks_t clk_ticks_o;
  logic           cpu_run_o;
  scm_mode_t      mode_o;
  int             errors = 0;
  int             n_checks = 0;
  int             c_cpu = 0, c_high = 0, c_sub = 0, c_slow = 0;
  int             d_cpu, d_high, d_sub, d_slow;
  scm_mode_t      halt_mode [4] = '{SCM_MODE_SLEEP, SCM_MODE_LOW_IDLE, SCM_MODE_HIGH_IDLE,
                                    SCM_MODE_FULL_IDLE};

  scm_clock_mode_ctrl #(.SETTLE_CYCLES(SETTLE)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o), .halt_i(halt_i), .wake_i(wake_i),
    .fast_osc_tick_i(fast_tick), .slow_osc_tick_i(slow_tick), .fast_osc_run_o(fast_run),
    .fast_osc_freq_o(fast_freq), .slow_osc_run_o(slow_run), .clk_ticks_o(clk_ticks_o),
    .cpu_run_o(cpu_run_o), .mode_o(mode_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    c_cpu  <= c_cpu + int'(clk_ticks_o.cpu_sys_clk);
    c_high <= c_high + int'(clk_ticks_o.high_clk);
    c_sub  <= c_sub + int'(clk_ticks_o.sub_clk);
    c_slow <= c_slow + int'(clk_ticks_o.slow_osc_clk);
  end

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t value got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t tick count got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    reg_req_i.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the read strobe edge
  task automatic reg_rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    reg_req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    reg_req_i.rd <= 1'b0;
    #1 chk_val(reg_rdata_o, exp);
  endtask

  task automatic ticks(input int n, input logic f, input logic s);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk_i);
      fast_tick <= f;
      slow_tick <= s;
      @(posedge ref_clk_i);
      fast_tick <= 1'b0;
      slow_tick <= 1'b0;
    end
  endtask

  task automatic measure(input int n, input logic f, input logic s);
    int a, b, c, d;
    // let the tick still in flight from earlier stimulus land before the window
    @(posedge ref_clk_i);
    #1;
    a = c_cpu;
    b = c_high;
    c = c_sub;
    d = c_slow;
    ticks(n, f, s);
    repeat (3) @(posedge ref_clk_i);
    #1;
    d_cpu = c_cpu - a;
    d_high = c_high - b;
    d_sub = c_sub - c;
    d_slow = c_slow - d;
  endtask

  task automatic settle();
    repeat (SETTLE + 12) @(posedge ref_clk_i);
  endtask

  task automatic step(input logic h, input logic w);
    @(posedge ref_clk_i);
    halt_i <= h;
    wake_i <= w;
    @(posedge ref_clk_i);
    halt_i <= 1'b0;
    wake_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic t_reset();
    reg_rd(2'h0, 8'h00);
    reg_rd(2'h1, 8'h01);
    chk_val({7'h00, slow_run}, 8'h01);
    settle();
    reg_rd(2'h1, 8'h03);
    reg_rd(2'h2, 8'h00);
    step(1'b0, 1'b1);
    chk_val({2'h0, mode_o}, {2'h0, SCM_MODE_FAST});
    $display("test reset done");
  endtask

  task automatic t_regs();
    reg_wr(2'h0, 8'hFF);
    reg_rd(2'h0, 8'hE3);
    reg_wr(2'h0, 8'h00);
    reg_wr(2'h1, 8'h0B);
    reg_rd(2'h1, 8'h09);
    chk_val({6'h00, fast_freq}, {6'h00, SCM_FREQ_8MHZ});
    settle();
    reg_rd(2'h1, 8'h0B);
    reg_wr(2'h1, 8'h0D);
    @(posedge ref_clk_i);
    #1;
    chk_val({6'h00, fast_freq}, {6'h00, SCM_FREQ_2MHZ});
    reg_wr(2'h1, 8'h05);
    @(posedge ref_clk_i);
    #1;
    chk_val({6'h00, fast_freq}, {6'h00, SCM_FREQ_4MHZ});
    reg_wr(2'h1, 8'h01);
    settle();
    $display("test registers done");
  endtask

  task automatic t_div();
    for (int k = 0; k < 7; k++) begin
      reg_wr(2'h0, {3'(k), 5'h00});
      ticks(64, 1'b1, 1'b0);
      measure(128, 1'b1, 1'b0);
      chk_cnt(16'(d_cpu), 16'(128 >> k));
      chk_cnt(16'(d_high), 16'd128);
    end
    $display("test divider done");
  endtask

  task automatic t_slow();
    reg_wr(2'h0, 8'hE0);
    ticks(64, 1'b1, 1'b1);
    measure(16, 1'b1, 1'b1);
    chk_cnt(16'(d_cpu), 16'd16);
    chk_cnt(16'(d_sub), 16'd16);
    chk_val({2'h0, mode_o}, {2'h0, SCM_MODE_SLOW});
    chk_val({7'h00, cpu_run_o}, 8'h01);
    reg_wr(2'h1, 8'h00);
    measure(8, 1'b1, 1'b1);
    chk_val({7'h00, fast_run}, 8'h00);
    chk_cnt(16'(d_high), 16'd0);
    reg_wr(2'h1, 8'h01);
    reg_rd(2'h1, 8'h01);
    settle();
    reg_rd(2'h1, 8'h03);
    chk_val({7'h00, fast_run}, 8'h01);
    $display("test slow mode done");
  endtask

  task automatic t_halt();
    logic s7;
    for (int s = 0; s < 2; s++) begin
      for (int kp = 0; kp < 4; kp++) begin
        s7 = (s == 1);
        reg_wr(2'h0, {{3{s7}}, 3'h0, 2'(kp)});
        ticks(64, 1'b1, 1'b1);
        settle();
        step(1'b1, 1'b0);
        chk_val({2'h0, mode_o}, {2'h0, halt_mode[kp]});
        chk_val({7'h00, cpu_run_o}, 8'h00);
        measure(16, 1'b1, 1'b1);
        chk_cnt(16'(d_cpu), (kp == 3 || (kp == 1) == s7) && kp != 0 ? 16'd16 : 16'd0);
        chk_cnt(16'(d_high), kp[1] ? 16'd16 : 16'd0);
        chk_cnt(16'(d_sub), kp[0] ? 16'd16 : 16'd0);
        chk_cnt(16'(d_slow), 16'd16);
        step(1'b1, 1'b0);
        chk_val({2'h0, mode_o}, {2'h0, halt_mode[kp]});
        step(1'b0, 1'b1);
        chk_val({2'h0, mode_o}, {2'h0, s7 ? SCM_MODE_SLOW : SCM_MODE_FAST});
        chk_val({7'h00, cpu_run_o}, 8'h01);
        reg_rd(2'h0, {{3{s7}}, 3'h0, 2'(kp)});
        settle();
      end
    end
    $display("test halt modes done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // the full run needs roughly 4800 cycles; allow ten times that
  initial begin
    #200000;
    errors++;
    $display("[ERR] t=%0t watchdog expired got=%h exp=%h", $time, 1'b0, 1'b1);
    print_verdict();
  end

  initial begin
    rst_n_i = 1'b0;
    reg_req_i = '0;
    halt_i = 1'b0;
    wake_i = 1'b0;
    fast_tick = 1'b0;
    slow_tick = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_regs();
    t_div();
    t_slow();
    t_halt();
    print_verdict();
  end
endmodule
`default_nettype wire
